// [logic/tsa_consts.svh]
// constants for the time slot program port
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH
`define TSA_WORD_BITS 8
`define TSA_SLOT_BITS 6
`define TSA_ID_BITS 5
`define TSA_CTRL_BITS 3
`define TSA_BITS_PER_SLOT 8
`define TSA_ACK_BIT 3
`define TSA_MODE_BOTH 2'b00
`define TSA_MODE_TX 2'b01
`define TSA_MODE_RX 2'b10
`define TSA_MODE_IDLE 2'b11
`endif

// [logic/tsa_pkg.sv]
// types for the time slot program port
package tsa_pkg;
	typedef enum logic [1:0]
	{
		TSA_READY = 2'b00,
		TSA_SHIFT = 2'b01,
		TSA_HELD = 2'b10
	} tsa_port_t;
endpackage

// [logic/tsa_program_port.sv]
// serial programming port and frame synchronised slot update
`timescale 1ns/100ps
`include "tsa_consts.svh"
module tsa_program_port
#(
	parameter bit ADDRESSED = 1'b1
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// host port pins
	input wire logic port_shift_clk_i,
	input wire logic group_select_i,
	input wire logic slot_word_in_i,
	input wire logic addr_word_in_i,
	input wire logic ack_in_i,
	output logic ack_out_o,
	output logic ack_oe_n_o,
	// identity straps
	input wire logic [`TSA_ID_BITS-1:0] hardwired_identity_i,
	// codec timing pins
	input wire logic codec_bit_clock_i,
	input wire logic tx_frame_sync_i,
	input wire logic rx_frame_sync_i,
	// hook status
	input wire logic hook_status_in_i,
	output logic hook_status_out_n_o,
	output logic hook_status_oe_n_o,
	// slot enables and control outputs
	output logic tx_slot_enable_o,
	output logic rx_slot_enable_o,
	output logic [`TSA_CTRL_BITS-1:0] line_control_bits_o,
	output logic powerdown_out_n_o
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// all pins resynchronised except the identity straps
	// serial data goes through the same two flops as the shift clock, so the bit
	// seen at the detected falling edge is the one that stood at the pin edge
	logic [8:0] sync1_q;
	logic [8:0] sync2_q;
	logic [8:0] prev_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_q <= 9'h000;
			sync2_q <= 9'h000;
			prev_q <= 9'h000;
		end
		else
		begin
			sync1_q <= {addr_word_in_i, slot_word_in_i, hook_status_in_i, ack_in_i,
				rx_frame_sync_i, tx_frame_sync_i, codec_bit_clock_i, port_shift_clk_i,
				group_select_i};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	logic sel_s;
	logic shift_fall;
	logic bit_rise;
	logic fst_s;
	logic fsr_s;
	logic hook_s;
	logic slot_s;
	logic addr_s;
	assign sel_s = sync2_q[0];
	assign slot_s = sync2_q[7];
	assign addr_s = sync2_q[8];
	assign shift_fall = prev_q[1] && !sync2_q[1];
	assign bit_rise = !prev_q[2] && sync2_q[2];
	assign fst_s = sync2_q[3];
	assign fsr_s = sync2_q[4];
	assign hook_s = sync2_q[6];

	// frame sync edges qualified on bit clock rise
	logic fst_seen_q;
	logic fsr_seen_q;
	logic fst_rise;
	logic fsr_rise;
	assign fst_rise = bit_rise && fst_s && !fst_seen_q;
	assign fsr_rise = bit_rise && fsr_s && !fsr_seen_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fst_seen_q <= 1'b0;
			fsr_seen_q <= 1'b0;
		end
		else if (bit_rise)
		begin
			fst_seen_q <= fst_s;
			fsr_seen_q <= fsr_s;
		end
	end

	// ------------------------------------------------------------
	// serial shift port
	// ------------------------------------------------------------
	tsa_pkg::tsa_port_t port_q;
	logic [`TSA_WORD_BITS-1:0] slot_sr_q;
	logic [`TSA_WORD_BITS-1:0] addr_sr_q;
	logic [3:0] shift_cnt_q;
	logic accepted;
	logic word_match;
	assign word_match = !ADDRESSED || (addr_sr_q[`TSA_ID_BITS-1:0] == hardwired_identity_i);
	assign accepted = (port_q == tsa_pkg::TSA_HELD) && word_match;

	logic acc1_q;
	logic acc2_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			acc1_q <= 1'b0;
			acc2_q <= 1'b0;
		end
		else
		begin
			acc1_q <= accepted;
			acc2_q <= acc1_q;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			port_q <= tsa_pkg::TSA_READY;
			slot_sr_q <= 8'h00;
			addr_sr_q <= 8'h00;
			shift_cnt_q <= 4'h0;
		end
		else if (!sel_s)
		begin
			port_q <= tsa_pkg::TSA_READY;
			shift_cnt_q <= 4'h0;
		end
		// back to ready after sync
		// a matching pair held too close to the sync waits one frame instead of being lost
		else if (fst_rise && port_q == tsa_pkg::TSA_HELD && (acc2_q || !word_match))
		begin
			port_q <= tsa_pkg::TSA_READY;
			shift_cnt_q <= 4'h0;
		end
		else if (shift_fall && port_q != tsa_pkg::TSA_HELD)
		begin
			// eight bits both words in parallel
			slot_sr_q <= {slot_sr_q[6:0], slot_s};
			addr_sr_q <= {addr_sr_q[6:0], addr_s};
			shift_cnt_q <= shift_cnt_q + 4'h1;
			port_q <= (shift_cnt_q == 4'h7) ? tsa_pkg::TSA_HELD : tsa_pkg::TSA_SHIFT;
		end
	end

	// ------------------------------------------------------------
	// active program and update at transmit sync
	// ------------------------------------------------------------
	logic [1:0] mode_q;
	logic [`TSA_SLOT_BITS-1:0] tx_slot_q;
	logic [`TSA_SLOT_BITS-1:0] rx_slot_q;
	logic tx_run_q;
	logic rx_run_q;
	logic tx_valid_q;
	logic [1:0] new_mode;
	// mode_bit_first arrives first, so sits in bit 7
	assign new_mode = slot_sr_q[7:6];
	logic update;
	assign update = fst_rise && acc2_q;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mode_q <= `TSA_MODE_IDLE;
			tx_slot_q <= 6'h00;
			rx_slot_q <= 6'h00;
			tx_run_q <= 1'b0;
			rx_run_q <= 1'b0;
			tx_valid_q <= 1'b0;
			line_control_bits_o <= 3'h0;
			powerdown_out_n_o <= 1'b1;
		end
		else if (update)
		begin
			mode_q <= new_mode;
			if (new_mode == `TSA_MODE_BOTH || new_mode == `TSA_MODE_TX)
			begin
				tx_slot_q <= slot_sr_q[5:0];
				tx_valid_q <= 1'b1;
			end
			if (new_mode != `TSA_MODE_TX)
				rx_slot_q <= slot_sr_q[5:0];
			tx_run_q <= (new_mode == `TSA_MODE_IDLE) ? 1'b0 :
				(new_mode == `TSA_MODE_RX) ? tx_run_q : 1'b1;
			rx_run_q <= (new_mode == `TSA_MODE_BOTH || new_mode == `TSA_MODE_RX);
			if (ADDRESSED)
				line_control_bits_o <= addr_sr_q[7:5];
			powerdown_out_n_o <= (new_mode != `TSA_MODE_IDLE);
		end
	end

	// ------------------------------------------------------------
	// slot timers
	// ------------------------------------------------------------
	logic tx_in_slot;
	logic rx_in_slot;
	logic hook_in_slot;
	logic [2:0] tx_bit;
	tsa_slot_timer u_tx
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.bit_en_i(bit_rise),
		.fs_rise_i(fst_s && !fst_seen_q),
		.run_i(tx_valid_q),
		.slot_i(tx_slot_q),
		.in_slot_o(tx_in_slot),
		.bit_in_frame_o(tx_bit)
	);
	tsa_slot_timer u_rx
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.bit_en_i(bit_rise),
		.fs_rise_i(fsr_s && !fsr_seen_q),
		.run_i(rx_run_q),
		.slot_i(rx_slot_q),
		.in_slot_o(rx_in_slot),
		.bit_in_frame_o()
	);
	assign hook_in_slot = tx_in_slot;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_slot_enable_o <= 1'b0;
			rx_slot_enable_o <= 1'b0;
			hook_status_out_n_o <= 1'b1;
			hook_status_oe_n_o <= 1'b1;
		end
		else
		begin
			tx_slot_enable_o <= tx_in_slot && tx_run_q;
			rx_slot_enable_o <= rx_in_slot;
			hook_status_out_n_o <= !hook_s;
			// only pull low; high comes from the pull-up
			hook_status_oe_n_o <= !(hook_in_slot && hook_s);
		end
	end

	// ------------------------------------------------------------
	// acknowledge
	// ------------------------------------------------------------
	logic ack_armed_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_armed_q <= 1'b0;
			ack_out_o <= 1'b0;
			ack_oe_n_o <= 1'b1;
		end
		else
		begin
			ack_out_o <= 1'b0;
			if (fst_rise && !ack_oe_n_o)
				ack_oe_n_o <= 1'b1;
			if (update)
				ack_armed_q <= 1'b1;
			if (ack_armed_q && bit_rise && tx_bit == 3'(`TSA_ACK_BIT - 1))
			begin
				ack_oe_n_o <= 1'b0;
				ack_armed_q <= 1'b0;
			end
		end
	end
endmodule

// [logic/tsa_slot_timer.sv]
// one direction slot counter and enable generator
`timescale 1ns/100ps
`include "tsa_consts.svh"
module tsa_slot_timer
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// bit clock rising edge and frame sync rising edge, both enables
	input wire logic bit_en_i,
	input wire logic fs_rise_i,
	// program
	input wire logic run_i,
	input wire logic [`TSA_SLOT_BITS-1:0] slot_i,
	// result
	output logic in_slot_o,
	output logic [2:0] bit_in_frame_o
);
	logic [2:0] bit_q;
	logic [`TSA_SLOT_BITS:0] slot_q;

	// frame sync restarts
	// counter saturates at 127, past slot 63, so it never wraps back to a programmed slot before the next frame sync
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bit_q <= 3'h0;
			slot_q <= 7'h7f;
		end
		else if (bit_en_i && fs_rise_i)
		begin
			bit_q <= 3'h0;
			slot_q <= 7'h00;
		end
		else if (bit_en_i)
		begin
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7 && slot_q != 7'h7f)
				slot_q <= slot_q + 7'h01;
		end
	end

	assign in_slot_o = run_i && (slot_q == {1'b0, slot_i});
	assign bit_in_frame_o = bit_q;
endmodule

// [tb/tsa_host_model.sv]
// host port model: serial words, select and acknowledge wait
`timescale 1ns/100ps
module tsa_host_model
(
	// clock
	input wire logic sys_clk_i,
	// port pins
	output logic shift_clk_o = 1'b0,
	output logic select_o = 1'b0,
	output logic slot_bit_o = 1'b0,
	output logic addr_bit_o = 1'b0,
	input wire logic ack_i
);
	// half a shift period, 100 ns keeps every level over three sys clocks
	task automatic half();
		repeat (4) @(negedge sys_clk_i);
	endtask
	// n shift pulses with select high, select left high
	task automatic send(input logic [7:0] di, input logic [7:0] ad, input int n);
		select_o = 1'b1;
		half();
		for (int i = 7; i > 7 - n; i--)
		begin
			// bits change with the rising shift edge
			shift_clk_o = 1'b1;
			// mode then slot bits, control then identity
			slot_bit_o = di[i];
			addr_bit_o = ad[i];
			half();
			shift_clk_o = 1'b0;
			half();
		end
	endtask
	// select drops only once acknowledge is back high
	task automatic release_select();
		while (ack_i !== 1'b1)
			half();
		select_o = 1'b0;
		half();
	endtask
endmodule

// [tb/tsa_program_port_properties.sv]
// pin level assertions for the program port
`timescale 1ns/100ps
`include "tsa_consts.svh"
module tsa_program_port_checker
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// watched pins
	input wire logic tx_frame_sync_i,
	input wire logic ack_out_o,
	input wire logic ack_oe_n_o,
	input wire logic hook_status_out_n_o,
	input wire logic hook_status_oe_n_o,
	input wire logic tx_slot_enable_o,
	input wire logic rx_slot_enable_o,
	input wire logic [`TSA_CTRL_BITS-1:0] line_control_bits_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// sys clocks spent high by each enable; 8 bit clocks of 8 sys clocks in the bench
	logic [7:0] tx_n_q;
	logic [7:0] rx_n_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tx_n_q <= 8'h00;
			rx_n_q <= 8'h00;
		end
		else
		begin
			tx_n_q <= tx_slot_enable_o ? tx_n_q + 8'h01 : 8'h00;
			rx_n_q <= rx_slot_enable_o ? rx_n_q + 8'h01 : 8'h00;
		end
	end
	property p_tx_len;
		$fell(tx_slot_enable_o) |-> tx_n_q inside {[63:65]};
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("tx enable width");
	property p_rx_len;
		$fell(rx_slot_enable_o) |-> rx_n_q inside {[63:65]};
	endproperty
	a_rx_len: assert property (p_rx_len) else $error("rx enable width");
	property p_hook_low;
		!hook_status_oe_n_o |-> !hook_status_out_n_o;
	endproperty
	a_hook_low: assert property (p_hook_low) else $error("hook drives high");
	property p_ack_zero;
		ack_out_o == 1'b0;
	endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("ack drives high");
	property p_ack_hold;
		$fell(ack_oe_n_o) |-> !ack_oe_n_o [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack glitch");
	property p_ack_fall;
		$fell(ack_oe_n_o) |-> $past(tx_frame_sync_i, 28);
	endproperty
	a_ack_fall: assert property (p_ack_fall) else $error("ack fall time");
	property p_ack_rise;
		$rose(ack_oe_n_o) |-> $past(tx_frame_sync_i, 4);
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack release time");
	property p_ctrl;
		!$stable(line_control_bits_o) |-> $past(tx_frame_sync_i, 4);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control changed off sync");
	c_ack: cover property ($fell(ack_oe_n_o));
	c_hook: cover property ($fell(hook_status_oe_n_o));
	c_rx: cover property ($rose(rx_slot_enable_o));
endmodule

bind tsa_program_port tsa_program_port_checker i_tsa_program_port_checker
(
	.sys_clk_i, .rst_n_i, .tx_frame_sync_i, .ack_out_o, .ack_oe_n_o,
	.hook_status_out_n_o, .hook_status_oe_n_o, .tx_slot_enable_o,
	.rx_slot_enable_o, .line_control_bits_o
);

// [tb/tsa_program_port_tb.sv]
// self-checking bench for the program port
`timescale 1ns/100ps
`include "tsa_consts.svh"
module tsa_program_port_tb;
	typedef struct packed {logic [7:0] di; logic [7:0] ad; bit ack; int chk; int pos;} tsa_row_t;
	localparam logic [4:0] SELF_ID = 5'h16; // arbitrary strap value
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic codec_bit_clock_i = 1'b0;
	logic tx_frame_sync_i = 1'b0;
	logic rx_frame_sync_i = 1'b0;
	logic hook_status_in_i = 1'b1;
	logic port_shift_clk_i, group_select_i, slot_word_in_i, addr_word_in_i, ack_in_i;
	logic ack_out_o, ack_oe_n_o, hook_status_out_n_o, hook_status_oe_n_o;
	logic tx_slot_enable_o, rx_slot_enable_o, powerdown_out_n_o;
	logic [2:0] line_control_bits_o;
	logic [2:0] exp_ctrl = 3'h0;
	logic exp_pd = 1'b1;
	int bitn = 0;
	int fails = 0;
	int compares = 0;
	// di, ad, ack expected, watched signal, bit where it must start
	tsa_row_t rows [5] = '{'{8'h01, 8'h76, 1, 0, 8}, '{8'h42, 8'hd6, 1, 0, 16},
		'{8'h83, 8'h36, 1, 1, 27}, '{8'hc0, 8'h96, 1, 2, 16}, '{8'h05, 8'hf5, 0, 0, 0}};
	always #12.5 sys_clk_i = ~sys_clk_i;
	always
	begin
		repeat (4) @(negedge sys_clk_i);
		codec_bit_clock_i = ~codec_bit_clock_i;
	end
	// 41 bit frame, last bit is the framing bit
	always @(posedge codec_bit_clock_i) bitn <= tx_frame_sync_i ? 0 : bitn + 1;
	// receive frame starts three bits after transmit
	always @(negedge codec_bit_clock_i)
	begin
		tx_frame_sync_i <= (bitn == 40);
		rx_frame_sync_i <= (bitn == 2);
	end
	// open drain acknowledge wire with pull-up
	assign ack_in_i = ack_oe_n_o ? 1'b1 : ack_out_o;
	tsa_host_model i_tsa_host_model (.sys_clk_i, .shift_clk_o(port_shift_clk_i),
		.select_o(group_select_i), .slot_bit_o(slot_word_in_i),
		.addr_bit_o(addr_word_in_i), .ack_i(ack_in_i));
	tsa_program_port #(.ADDRESSED(1'b1)) i_tsa_program_port (.sys_clk_i, .rst_n_i,
		.port_shift_clk_i, .group_select_i, .slot_word_in_i, .addr_word_in_i, .ack_in_i,
		.ack_out_o, .ack_oe_n_o, .hardwired_identity_i(SELF_ID), .codec_bit_clock_i,
		.tx_frame_sync_i, .rx_frame_sync_i, .hook_status_in_i, .hook_status_out_n_o,
		.hook_status_oe_n_o, .tx_slot_enable_o, .rx_slot_enable_o, .line_control_bits_o,
		.powerdown_out_n_o);
	task automatic check(input bit ok, input string what);
		compares++;
		if (!ok)
		begin
			fails++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	function automatic logic seen(input int c);
		case (c)
			0: return tx_slot_enable_o;
			1: return rx_slot_enable_o;
			2: return !hook_status_oe_n_o;
			3: return !ack_in_i;
			default: return ack_in_i;
		endcase
	endfunction
	task automatic wait_for(input int c, input int lim, output bit got);
		got = 1'b0;
		repeat (lim)
		begin
			@(negedge sys_clk_i);
			if (seen(c) === 1'b1)
			begin
				got = 1'b1;
				break;
			end
		end
	endtask
	task automatic run_row(input tsa_row_t r);
		bit got;
		check(ack_in_i === 1'b1, "ack idle before send");
		i_tsa_host_model.send(r.di, r.ad, 8);
		wait_for(3, 800, got);
		check(got === r.ack, "ack presence");
		if (got)
		begin
			check(bitn === `TSA_ACK_BIT, "ack bit");
			exp_ctrl = r.ad[7:5];
			exp_pd = (r.di[7:6] != `TSA_MODE_IDLE);
			wait_for(4, 400, got);
			check(got && bitn === 0, "ack release");
			wait_for(r.chk, 400, got);
			check(got && bitn === r.pos, "slot start");
			check(r.chk != 2 || (!tx_slot_enable_o && !hook_status_out_n_o), "idle");
		end
		check(line_control_bits_o === exp_ctrl, "control bits");
		check(powerdown_out_n_o === exp_pd, "power down");
		$display("row done at %0t", $time);
	endtask
	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		bit got;
		repeat (4) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		@(negedge sys_clk_i);
		check(ack_oe_n_o === 1'b1 && hook_status_oe_n_o === 1'b1, "reset pins");
		check(line_control_bits_o === 3'h0 && powerdown_out_n_o === 1'b1, "reset state");
		$display("reset test done");
		foreach (rows[i])
			run_row(rows[i]);
		// partial word then select low must leave no stray bits behind
		i_tsa_host_model.send(8'hff, 8'hf6, 5);
		i_tsa_host_model.release_select();
		run_row('{8'h00, 8'hb6, 1, 0, 0});
		// hook input low: the open drain output must stay released in the slot
		hook_status_in_i = 1'b0;
		repeat (100) @(negedge sys_clk_i);
		wait_for(0, 400, got);
		check(got && hook_status_oe_n_o === 1'b1, "hook released");
		hook_status_in_i = 1'b1;
		wait_for(2, 400, got);
		check(got && tx_slot_enable_o === 1'b1, "hook pulled in slot");
		$display("hook test done");
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		$display("BAD %0t watchdog expired", $time);
		final_report();
	end
endmodule
